// file: design/pmc_defs.vh
// register map, field positions and reset values of the write-side monitor channel 0
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

`define PMC_ADDR_W          12
`define PMC_OFF_CONTROL     12'h0800
`define PMC_OFF_WR_DATA     12'h0810
`define PMC_OFF_WR_STALL    12'h0814
`define PMC_OFF_WR_LAT      12'h0818

`define PMC_BIT_ENABLE      0
`define PMC_BIT_FREEZE      4
`define PMC_BIT_CLEAR       8
`define PMC_SEL_LSB         16
`define PMC_SEL_W           4

`define PMC_CNT_W           32
`define PMC_LAT_W           16
`define PMC_NUM_CH          12

`define PMC_RST_WORD        32'h0000_0000
`define PMC_CNT_MAX         32'hFFFF_FFFF

`endif

// file: design/pmc_lat_track.v
// saturating tracker of the longest request-to-start wait of one transfer stream
`timescale 1ns/1ps
module pmc_lat_track #(
  parameter LAT_W = 16
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clear,
  input  wire             active,
  input  wire             req,
  input  wire             start,
  output reg  [LAT_W-1:0] max_lat
);

  localparam [LAT_W-1:0] LAT_TOP  = {LAT_W{1'b1}};
  localparam [LAT_W-1:0] LAT_ZERO = {LAT_W{1'b0}};

  reg [LAT_W-1:0] cur_lat;

  // ----------------------------------------------------------------
  // current wait and recorded maximum
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_lat <= LAT_ZERO;
      max_lat <= LAT_ZERO;
    end else if (clear) begin
      // only the software clear empties the maximum [R2]
      cur_lat <= LAT_ZERO;
      max_lat <= LAT_ZERO;
    end else if (active) begin
      if (start) begin
        cur_lat <= LAT_ZERO;
        if (cur_lat > max_lat) begin
          max_lat <= cur_lat; // [R7]
        end
      end else if (req && cur_lat != LAT_TOP) begin
        // hold at the top instead of wrapping [R1] [R3]
        cur_lat <= cur_lat + 1'b1;
      end
    end
  end

endmodule // pmc_lat_track

// file: design/pmc_monitor.v
// write-side performance monitor channel 0 with its apb register slave
//
// Overview of operation
// R1: maximum-latency counter saturates at its top value instead of wrapping.
// R2: maximum latency is cleared only by writing one to the counter clear bit.
// R3: all counters advance once per bus clock cycle of the monitored stream.
// R4: read-only 32-bit write data cycle count at 0x810.
// R5: read-only 32-bit write stall cycle count at 0x814.
// R6: write maximum latency at 0x818, 16-bit field in bits 15:0, read/write; writes are accepted but leave the field unchanged.
// R7: latency field keeps the largest request-to-start wait seen since clear.
// R8: clear bit set to one clears counters; zero does nothing; reads zero.
// R9: freeze bit 0 resets counters on overflow; 1 freezes them before overflow.
// R10: channel select picks which dma channel this monitor observes.
// R11: counting happens only while the enable bit is one.
// R12: latency register bits 31:16 read zero and ignore writes.
`timescale 1ns/1ps
`include "pmc_defs.vh"
module pmc_monitor #(
  parameter NUM_CH = `PMC_NUM_CH,
  parameter SEL_W  = `PMC_SEL_W,
  parameter CNT_W  = `PMC_CNT_W,
  parameter LAT_W  = `PMC_LAT_W
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire [NUM_CH-1:0] dma_wr_req,
  input  wire [NUM_CH-1:0] dma_wr_start,
  input  wire [NUM_CH-1:0] dma_wr_data_cycle,
  input  wire [NUM_CH-1:0] dma_wr_stall_cycle
);

  localparam [CNT_W-1:0] CNT_TOP  = {CNT_W{1'b1}};
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // picks the line of the observed dma channel; out-of-range reads zero
  function pick;
    input [NUM_CH-1:0] lines;
    input [SEL_W-1:0]  sel;
    begin
      pick = (sel < NUM_CH) ? lines[sel] : 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  reg              monitor0_enable;
  reg              monitor0_overflow_freeze;
  reg [SEL_W-1:0]  monitor0_channel_select;
  reg [CNT_W-1:0]  ch0_write_data_cycle_count;
  reg [CNT_W-1:0]  ch0_write_stall_cycle_count;
  wire [LAT_W-1:0] ch0_write_max_latency;

  wire [`PMC_ADDR_W-1:0] offset = paddr[`PMC_ADDR_W-1:0];
  wire access   = psel && penable && !pready;
  wire complete = psel && penable && pready;
  wire wr_ctrl  = complete && pwrite && (offset == `PMC_OFF_CONTROL);
  wire monitor0_counter_clear = wr_ctrl && pwdata[`PMC_BIT_CLEAR]; // [R8]

  // ----------------------------------------------------------------
  // observed stream
  // ----------------------------------------------------------------
  wire sel_req   = pick(dma_wr_req, monitor0_channel_select);         // [R10]
  wire sel_start = pick(dma_wr_start, monitor0_channel_select);       // [R10]
  wire sel_data  = pick(dma_wr_data_cycle, monitor0_channel_select);  // [R10]
  wire sel_stall = pick(dma_wr_stall_cycle, monitor0_channel_select); // [R10]

  // both counters stop once either reaches all-ones when freezing is chosen, so the next
  // increment never wraps and the latency record stops with them
  wire at_top  = (ch0_write_data_cycle_count == CNT_TOP) ||
                 (ch0_write_stall_cycle_count == CNT_TOP);
  wire frozen  = monitor0_overflow_freeze && at_top;                  // [R9]
  wire counting = monitor0_enable && !frozen;                          // [R11]
  wire data_ovf  = sel_data && (ch0_write_data_cycle_count == CNT_TOP);
  wire stall_ovf = sel_stall && (ch0_write_stall_cycle_count == CNT_TOP);
  wire wrap_reset = counting && !monitor0_overflow_freeze && (data_ovf || stall_ovf);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  reg             next_enable;
  reg             next_freeze;
  reg [SEL_W-1:0] next_select;

  always @* begin
    next_enable = monitor0_enable;
    next_freeze = monitor0_overflow_freeze;
    next_select = monitor0_channel_select;
    if (wr_ctrl) begin
      // every field comes from one write, there is no partial update
      next_enable = pwdata[`PMC_BIT_ENABLE];
      next_freeze = pwdata[`PMC_BIT_FREEZE];
      next_select = pwdata[`PMC_SEL_LSB +: SEL_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor0_enable          <= 1'b0;
      monitor0_overflow_freeze <= 1'b0;
      monitor0_channel_select  <= {SEL_W{1'b0}};
    end else begin
      monitor0_enable          <= next_enable;
      monitor0_overflow_freeze <= next_freeze;
      monitor0_channel_select  <= next_select;
    end
  end

  // ----------------------------------------------------------------
  // data and stall cycle counters
  // ----------------------------------------------------------------
  // next values are formed apart from the flip-flops so that the
  // priority of clear, wrap and count reads in one place
  reg [CNT_W-1:0] next_data_count;
  reg [CNT_W-1:0] next_stall_count;

  always @* begin
    next_data_count  = ch0_write_data_cycle_count;
    next_stall_count = ch0_write_stall_cycle_count;
    if (monitor0_counter_clear || wrap_reset) begin
      // clear wins over a count in the same cycle [R8] [R9]
      next_data_count  = CNT_ZERO;
      next_stall_count = CNT_ZERO;
    end else if (counting) begin
      if (sel_data) begin
        next_data_count = ch0_write_data_cycle_count + 1'b1; // [R4] [R3]
      end
      if (sel_stall) begin
        next_stall_count = ch0_write_stall_cycle_count + 1'b1; // [R5] [R3]
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch0_write_data_cycle_count  <= CNT_ZERO;
      ch0_write_stall_cycle_count <= CNT_ZERO;
    end else begin
      ch0_write_data_cycle_count  <= next_data_count;
      ch0_write_stall_cycle_count <= next_stall_count;
    end
  end

  // ----------------------------------------------------------------
  // maximum initiation latency
  // ----------------------------------------------------------------
  pmc_lat_track #(
    .LAT_W (LAT_W)
  ) u_lat (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (monitor0_counter_clear), // [R2]
    .active  (counting),               // [R11] [R9]
    .req     (sel_req),
    .start   (sel_start),
    .max_lat (ch0_write_max_latency)   // [R7]
  );

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // ----------------------------------------------------------------
  // the answer is registered so every output leaves a flip-flop; the
  // price is one fixed wait state on each transfer
  reg [31:0] next_prdata;
  reg        next_pslverr;

  always @* begin
    next_prdata  = `PMC_RST_WORD;
    next_pslverr = 1'b0;
    case (offset)
      `PMC_OFF_CONTROL: begin
        // clear bit always reads zero [R8]
        next_prdata[`PMC_BIT_ENABLE]            = monitor0_enable;
        next_prdata[`PMC_BIT_FREEZE]            = monitor0_overflow_freeze;
        next_prdata[`PMC_SEL_LSB +: SEL_W]      = monitor0_channel_select;
      end
      `PMC_OFF_WR_DATA: begin
        next_prdata[CNT_W-1:0] = ch0_write_data_cycle_count;  // [R4]
        next_pslverr = pwrite;
      end
      `PMC_OFF_WR_STALL: begin
        next_prdata[CNT_W-1:0] = ch0_write_stall_cycle_count; // [R5]
        next_pslverr = pwrite;
      end
      `PMC_OFF_WR_LAT: begin
        // writes accepted but change nothing; upper half reads zero [R6] [R12]
        next_prdata[LAT_W-1:0] = ch0_write_max_latency;
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PMC_RST_WORD;
    end else if (access) begin
      pready  <= 1'b1;
      pslverr <= next_pslverr;
      prdata  <= pwrite ? `PMC_RST_WORD : next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PMC_RST_WORD;
    end
  end

endmodule // pmc_monitor

// file: bench/pmc_monitor_sva.sv
// apb side assertions of the write monitor channel 0
`timescale 1ns/1ps
module pmc_monitor_sva (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  wire [11:0] a    = paddr[11:0];
  wire        done = pready && psel && penable;
  wire        mapd = a == 12'h800 || a == 12'h810 || a == 12'h814 || a == 12'h818;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  AST_ONE_PULSE: assert property (pready |=> !pready) else $error("pready too long");
  AST_RO_WRITE: assert property (done && pwrite && (a == 12'h810 || a == 12'h814) |-> pslverr)
    else $error("counter write not refused");
  AST_LAT_RW: assert property (done && a == 12'h818 |-> !pslverr)
    else $error("latency access refused");
  AST_LAT_RSV: assert property (done && !pwrite && a == 12'h818 |-> prdata[31:16] == 16'h0000)
    else $error("latency upper bits set");
  AST_CLR_ZERO: assert property (done && !pwrite && a == 12'h800 |-> !prdata[8])
    else $error("clear bit reads one");
  AST_UNMAPPED: assert property (done && !mapd |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access accepted");
  AST_CTL_OK: assert property (done && a == 12'h800 |-> !pslverr) else $error("control refused");
  AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("outputs set while idle");
endmodule // pmc_monitor_sva

bind pmc_monitor pmc_monitor_sva i_pmc_monitor_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

// file: bench/pmc_dma_model.sv
// behavioural dma controller driving the write transfer lines of all channels
`timescale 1ns/1ps
module pmc_dma_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        run,
  input  wire [31:0] rnd,
  output reg  [11:0] req,
  output reg  [11:0] start,
  output reg  [11:0] dat,
  output reg  [11:0] stl
);
  reg [2:0] w;
  // a begun wait always ends in a start, so stopping never strands a request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w     <= 3'h0;
      req   <= 12'h000;
      start <= 12'h000;
    end else if (w != 3'h0) begin
      req   <= 12'hFFF;
      start <= 12'h000;
      w     <= w - 3'h1;
    end else begin
      start <= req;
      req   <= 12'h000;
      w     <= (run && req == 12'h000) ? rnd[2:0] : 3'h0;
    end
  end
  // a data cycle and a stall cycle never fall together
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat <= 12'h000;
      stl <= 12'h000;
    end else begin
      dat <= run ? rnd[14:3] : 12'h000;
      stl <= run ? rnd[26:15] & ~rnd[14:3] : 12'h000;
    end
  end
endmodule // pmc_dma_model

// file: bench/dma_perf_monitor_ch0_tb.sv
// random and directed test of the write monitor channel 0
`timescale 1ns/1ps
module dma_perf_monitor_ch0_tb;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, rnd = 32'h7495_0267;
  reg  [31:0] ed = 32'h0000_0000, es = 32'h0000_0000, el = 32'h0000_0000, r;
  reg         run = 1'b0, en = 1'b0, e;
  reg         psel_s = 1'b0, tgt = 1'b0, en_s = 1'b0, frz_s = 1'b0;
  reg  [3:0]  sel = 4'h0;
  reg  [3:0]  sel_s = 4'h0, sd = 4'h0, ss = 4'h0;
  reg  [1:0]  sl = 2'h0, ks = 2'h0;
  wire [31:0] prdata, prdata_s;
  wire        pready, pslverr, pready_s, pslverr_s;
  wire [11:0] req, start, dat, stl;
  integer     miscompares = 0, check_count = 0, k = 0, i;
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) rnd <= xs(rnd);
  // expected counts follow the selected channel's lines while enabled
  always @(posedge pclk) if (en) begin
    ed = ed + dat[sel];
    es = es + stl[sel];
    if (start[sel]) begin
      if (k > el) el = k;
      k = 0;
    end else if (req[sel]) k = k + 1;
  end
  // narrow copy: wraps or freezes at 4'hF, latency saturates at 2'h3
  always @(posedge pclk) if (en_s && !(frz_s && (sd == 4'hF || ss == 4'hF))) begin
    if ((dat[sel_s] && sd == 4'hF) || (stl[sel_s] && ss == 4'hF)) begin
      sd = 4'h0;
      ss = 4'h0;
    end else begin
      sd = sd + dat[sel_s];
      ss = ss + stl[sel_s];
    end
    if (start[sel_s]) begin
      if (ks > sl) sl = ks;
      ks = 2'h0;
    end else if (req[sel_s] && ks != 2'h3) ks = ks + 2'h1;
  end
  pmc_dma_model i_pmc_dma_model (.pclk(pclk), .presetn(presetn), .run(run), .rnd(rnd),
    .req(req), .start(start), .dat(dat), .stl(stl));
  pmc_monitor i_pmc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_wr_req(req), .dma_wr_start(start), .dma_wr_data_cycle(dat),
    .dma_wr_stall_cycle(stl));
  // narrow copy so that wrap, freeze and saturation are reached within the run
  pmc_monitor #(.CNT_W(4), .LAT_W(2)) i_pmc_monitor_small (.pclk(pclk), .presetn(presetn),
    .psel(psel_s), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s), .dma_wr_req(req),
    .dma_wr_start(start), .dma_wr_data_cycle(dat), .dma_wr_stall_cycle(stl));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= !tgt;
      psel_s <= tgt;
      pwrite <= w;
      paddr <= {20'h0_0000, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while ((tgt ? pready_s : pready) !== 1'b1);
      r = tgt ? prdata_s : prdata;
      e = tgt ? pslverr_s : pslverr;
      psel <= 1'b0;
      psel_s <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] ex, input ee);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(r, ex);
      chk({31'h0, e}, {31'h0, ee});
    end
  endtask
  // whole run is about 2000 cycles
  initial begin
    #200_000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h810, 32'h0000_0000, 1'b0);
    rd(12'h814, 32'h0000_0000, 1'b0);
    rd(12'h818, 32'h0000_0000, 1'b0);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      sel = (i == 0) ? 4'd11 : 4'(rnd % 12);
      en = (i != 2);
      ed = 0;
      es = 0;
      el = 0;
      apb(1'b1, 12'h800, {12'h000, sel, 7'h00, 1'b1, 7'h00, en});
      rd(12'h800, {12'h000, sel, 15'h0000, en}, 1'b0);
      run <= 1'b1;
      repeat (300) @(posedge pclk);
      run <= 1'b0;
      repeat (12) @(posedge pclk);
      rd(12'h810, ed, 1'b0);
      rd(12'h814, es, 1'b0);
      rd(12'h818, el, 1'b0);
      $display("test window %0d done", i);
    end
    apb(1'b1, 12'h818, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h0000_0000);
    rd(12'h818, el, 1'b0);
    apb(1'b1, 12'h810, 32'h0000_0001);
    chk({31'h0, e}, 32'h0000_0001);
    rd(12'h810, ed, 1'b0);
    rd(12'h81C, 32'h0000_0000, 1'b1);
    en = 1'b0;
    apb(1'b1, 12'h800, 32'h0000_0100);
    rd(12'h818, 32'h0000_0000, 1'b0);
    rd(12'h800, 32'h0000_0000, 1'b0);
    $display("test access done");
    tgt = 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      sel_s = 4'(rnd % 12);
      frz_s = i[0];
      sd = 4'h0;
      ss = 4'h0;
      sl = 2'h0;
      ks = 2'h0;
      en_s = 1'b1;
      apb(1'b1, 12'h800, {12'h000, sel_s, 7'h00, 1'b1, 3'h0, frz_s, 3'h0, 1'b1});
      run <= 1'b1;
      repeat (300) @(posedge pclk);
      run <= 1'b0;
      repeat (12) @(posedge pclk);
      rd(12'h810, {28'h000_0000, sd}, 1'b0);
      rd(12'h814, {28'h000_0000, ss}, 1'b0);
      rd(12'h818, {30'h0000_0000, sl}, 1'b0);
      $display("test overflow %0d done", i);
    end
    tgt = 1'b0;
    rd(12'h810, 32'h0000_0000, 1'b0);
    summarize;
  end
endmodule // dma_perf_monitor_ch0_tb
